//--- rtl/prog_entry_defs.svh
// constants for the serial programming entry logic
// assumes inclusion by bare name from the rtl files
`ifndef PROG_ENTRY_DEFS_SVH
`define PROG_ENTRY_DEFS_SVH
`define KEY_BITS 32
`define KEY_DEFAULT 32'h1234_5678
`define WORD_BITS 14
`define ADDR_BITS 16
`define READ_CNT_BITS 4
`define LVP_CFG_ADDR 16'h8007
`define LVP_CFG_BIT 13
`define TGT_PROGRAM 2'h0
`define TGT_EEPROM 2'h1
`define TGT_USER_ID 2'h2
`define TGT_CONFIG 2'h3
`endif

//--- rtl/prog_entry_pkg.sv
// types of the serial programming entry logic
// assumes prog_entry_defs.svh holds the numeric constants
package prog_entry_pkg;
  typedef enum logic [1:0] {
    mode_normal,
    mode_key_wait,
    mode_prog_hv,
    mode_prog_lv
  } prog_mode_e;
  typedef logic [13:0] word_t;
endpackage

//--- rtl/prog_link_if.sv
// carrier between the system-clock entry logic and the link-clock shifter
// assumes both ends follow a four-phase handshake for readback words
interface prog_link_if;
  logic key_arm;
  logic key_seen;
  logic rd_req;
  logic rd_ack;
  logic [13:0] rd_word;
  logic sys_rst_n;
  modport sys (output key_arm, output rd_req, output rd_word, output sys_rst_n,
    input key_seen, input rd_ack);
  modport link (input key_arm, input rd_req, input rd_word, input sys_rst_n,
    output key_seen, output rd_ack);
endinterface

//--- rtl/prog_key_shifter.sv
// link-clock logic: key capture and readback shift on the programming clock
// assumes the programmer changes data while the clock is low and samples while it is high
`include "prog_entry_defs.svh"
module prog_key_shifter #(
  parameter logic [31:0] KEY = `KEY_DEFAULT
) (
  // link clock and pins
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  // carrier to system domain
  prog_link_if.link lnk
);
  logic rst_q1, rst_q2, arm_q1, arm_q2, req_q1, req_q2;
  logic [`KEY_BITS-1:0] shift_q;
  logic [`READ_CNT_BITS-1:0] cnt_q;
  logic key_seen_q, ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; the clock may stall so these only settle during frames
  always_ff @(posedge prog_serial_clock) begin
    rst_q1 <= lnk.sys_rst_n;
    rst_q2 <= rst_q1;
    arm_q1 <= lnk.key_arm;
    arm_q2 <= arm_q1;
    req_q1 <= lnk.rd_req;
    req_q2 <= req_q1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sliding window keeps bits clocked before the arm level arrived
  always_ff @(posedge prog_serial_clock) begin
    if (!rst_q2) begin
      shift_q <= '0;
      key_seen_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[`KEY_BITS-2:0], prog_serial_data_in};
      if (!arm_q2)
        key_seen_q <= 1'b0;
      else if ({shift_q[`KEY_BITS-2:0], prog_serial_data_in} == KEY)
        key_seen_q <= 1'b1;
    end
  end
  assign lnk.key_seen = key_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // readback: msb first, one bit per rising edge, then ack until req drops
  always_ff @(posedge prog_serial_clock) begin
    if (!rst_q2) begin
      cnt_q <= '0;
      ack_q <= 1'b0;
      prog_serial_data_out <= 1'b0;
      prog_serial_data_oe <= 1'b0;
    end else if (req_q2 && !ack_q) begin
      prog_serial_data_oe <= 1'b1;
      prog_serial_data_out <= lnk.rd_word[4'(`WORD_BITS - 1) - cnt_q];
      if (cnt_q == 4'(`WORD_BITS - 1)) begin
        cnt_q <= '0;
        ack_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      prog_serial_data_oe <= 1'b0;
      if (!req_q2)
        ack_q <= 1'b0;
    end
  end
  assign lnk.rd_ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  key_needs_arm_a: assert property (@(posedge prog_serial_clock) disable iff (!rst_q2)
    $rose(key_seen_q) |-> $past(arm_q2))
    else $error("key flag rose without arm");
  drive_only_req_a: assert property (@(posedge prog_serial_clock) disable iff (!rst_q2)
    prog_serial_data_oe |-> $past(req_q2))
    else $error("data driven without read request");
  read_cover_c: cover property (@(posedge prog_serial_clock) disable iff (!rst_q2)
    $rose(ack_q));
endmodule

//--- rtl/serial_programming_entry.sv
// serial programming entry: high-voltage and key entry, write gating, readback
// assumes pins pass through analog front ends giving digital levels
`include "prog_entry_defs.svh"
module serial_programming_entry #(
  parameter logic [31:0] KEY = `KEY_DEFAULT
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // programming link pins
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe,
  input wire logic master_clear_n,
  input wire logic high_prog_voltage_level,
  // configuration levels
  input wire logic low_voltage_prog_enable,
  input wire logic master_clear_n_enable_cfg,
  // serial command decoder write request
  input wire logic ser_wr_valid,
  input wire logic [1:0] ser_wr_target,
  input wire logic [`ADDR_BITS-1:0] ser_wr_addr,
  input wire logic [`WORD_BITS-1:0] ser_wr_data,
  // core write request
  input wire logic core_wr_valid,
  input wire logic [1:0] core_wr_target,
  input wire logic [`ADDR_BITS-1:0] core_wr_addr,
  input wire logic [`WORD_BITS-1:0] core_wr_data,
  // readback request
  input wire logic rd_valid,
  input wire prog_entry_pkg::word_t rd_word,
  output logic rd_busy,
  // memory write port
  output logic nvm_wr_en,
  output logic [1:0] nvm_wr_target,
  output logic [`ADDR_BITS-1:0] nvm_wr_addr,
  output logic [`WORD_BITS-1:0] nvm_wr_data,
  output logic wr_refused,
  // status
  output logic prog_mode,
  output logic prog_mode_hv,
  output logic master_clear_n_reset_enable,
  output logic core_reset_n
);
  prog_link_if lnk ();

  logic master_clear_n_q1, master_clear_n_q2, hv_q1, hv_q2, pclk_q1, pclk_q2, pdat_q1, pdat_q2;
  logic seen_q1, seen_q2, ack_q1, ack_q2;
  logic hv_prev_q;
  prog_entry_pkg::prog_mode_e mode_q, mode_d;
  logic arm_q, req_q;
  prog_entry_pkg::word_t rd_word_q;
  logic in_prog, clears_lvp, ser_ok, core_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stages feed only second stages
  always_ff @(posedge clk_sys) begin
    master_clear_n_q1 <= master_clear_n;
    master_clear_n_q2 <= master_clear_n_q1;
    hv_q1 <= high_prog_voltage_level;
    hv_q2 <= hv_q1;
    pclk_q1 <= prog_serial_clock;
    pclk_q2 <= pclk_q1;
    pdat_q1 <= prog_serial_data_in;
    pdat_q2 <= pdat_q1;
    seen_q1 <= lnk.key_seen;
    seen_q2 <= seen_q1;
    ack_q1 <= lnk.rd_ack;
    ack_q2 <= ack_q1;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      hv_prev_q <= 1'b0;
    else
      hv_prev_q <= hv_q2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry state machine
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      prog_entry_pkg::mode_normal: begin
        // high voltage only counts with clock and data seen low at the rise
        if (hv_q2 && !hv_prev_q && !pclk_q2 && !pdat_q2)
          mode_d = prog_entry_pkg::mode_prog_hv;
        else if (!master_clear_n_q2 && low_voltage_prog_enable)
          mode_d = prog_entry_pkg::mode_key_wait;
      end
      prog_entry_pkg::mode_key_wait: begin
        if (master_clear_n_q2 || !low_voltage_prog_enable)
          mode_d = prog_entry_pkg::mode_normal;
        else if (seen_q2)
          mode_d = prog_entry_pkg::mode_prog_lv;
      end
      prog_entry_pkg::mode_prog_hv: begin
        if (!hv_q2)
          mode_d = prog_entry_pkg::mode_normal;
      end
      prog_entry_pkg::mode_prog_lv: begin
        if (master_clear_n_q2)
          mode_d = prog_entry_pkg::mode_normal;
      end
      default: mode_d = prog_entry_pkg::mode_normal;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      mode_q <= prog_entry_pkg::mode_normal;
    else
      mode_q <= mode_d;
  end

  // arm stays high through the session so the link keeps its key flag
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      arm_q <= 1'b0;
    else
      arm_q <= (mode_d == prog_entry_pkg::mode_key_wait) ||
               (mode_d == prog_entry_pkg::mode_prog_lv);
  end

  assign in_prog = (mode_q == prog_entry_pkg::mode_prog_hv) ||
                   (mode_q == prog_entry_pkg::mode_prog_lv);

  ////////////////////////////////////////////////////////////////////////////
  // status and reset outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prog_mode <= 1'b0;
      prog_mode_hv <= 1'b0;
      master_clear_n_reset_enable <= 1'b1;
      core_reset_n <= 1'b0;
    end else begin
      prog_mode <= in_prog;
      prog_mode_hv <= (mode_q == prog_entry_pkg::mode_prog_hv);
      master_clear_n_reset_enable <= master_clear_n_enable_cfg | low_voltage_prog_enable;
      // core held while programming or while an enabled master clear is low
      core_reset_n <= !in_prog && !(!master_clear_n_q2 &&
                      (master_clear_n_enable_cfg | low_voltage_prog_enable));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write gating: serial writes only in program mode, core writes only outside
  assign clears_lvp = (ser_wr_target == `TGT_CONFIG) &&
                      (ser_wr_addr == `LVP_CFG_ADDR) &&
                      !ser_wr_data[`LVP_CFG_BIT];
  assign ser_ok = ser_wr_valid && in_prog && !(clears_lvp &&
                  (mode_q != prog_entry_pkg::mode_prog_hv));
  assign core_ok = core_wr_valid && !in_prog;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      nvm_wr_en <= 1'b0;
      nvm_wr_target <= `TGT_PROGRAM;
      nvm_wr_addr <= '0;
      nvm_wr_data <= '0;
      wr_refused <= 1'b0;
    end else begin
      nvm_wr_en <= ser_ok || core_ok;
      wr_refused <= (ser_wr_valid && !ser_ok) || (core_wr_valid && in_prog);
      if (ser_ok) begin
        nvm_wr_target <= ser_wr_target;
        nvm_wr_addr <= ser_wr_addr;
        nvm_wr_data <= ser_wr_data;
      end else if (core_ok) begin
        nvm_wr_target <= core_wr_target;
        nvm_wr_addr <= core_wr_addr;
        nvm_wr_data <= core_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback handshake; word is frozen while the request is up
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      rd_word_q <= '0;
    end else if (!req_q && !ack_q2 && rd_valid && in_prog) begin
      req_q <= 1'b1;
      rd_word_q <= rd_word;
    end else if (req_q && ack_q2) begin
      req_q <= 1'b0;
    end
  end
  assign rd_busy = req_q || ack_q2;

  ////////////////////////////////////////////////////////////////////////////
  // link-clock side
  assign lnk.key_arm = arm_q;
  assign lnk.rd_req = req_q;
  assign lnk.rd_word = rd_word_q;
  assign lnk.sys_rst_n = reset_n;

  prog_key_shifter #(
    .KEY(KEY)
  ) u_shifter (
    .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_in(prog_serial_data_in),
    .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe(prog_serial_data_oe),
    .lnk(lnk.link)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  hv_needs_low_a: assert property ($rose(mode_q == prog_entry_pkg::mode_prog_hv) |->
    $past(!pclk_q2 && !pdat_q2))
    else $error("high voltage entry without low clock and data");
  lv_needs_enable_a: assert property ((mode_q == prog_entry_pkg::mode_prog_lv) &&
    $past(mode_q) == prog_entry_pkg::mode_key_wait |-> $past(low_voltage_prog_enable))
    else $error("key entry taken while disabled");
  lvp_clear_hv_a: assert property (nvm_wr_en && nvm_wr_target == `TGT_CONFIG &&
    nvm_wr_addr == `LVP_CFG_ADDR && !nvm_wr_data[`LVP_CFG_BIT] && $past(in_prog)
    |-> $past(mode_q == prog_entry_pkg::mode_prog_hv))
    else $error("enable bit cleared outside high voltage entry");
  master_clear_n_forced_a: assert property (low_voltage_prog_enable |=> master_clear_n_reset_enable)
    else $error("master clear reset not forced");
  key_match_a: assert property ($rose(mode_q == prog_entry_pkg::mode_prog_lv) |->
    $past(seen_q2))
    else $error("key entry without matched key");
  release_exit_a: assert property (mode_q == prog_entry_pkg::mode_prog_lv && master_clear_n_q2
    |=> mode_q == prog_entry_pkg::mode_normal)
    else $error("program mode kept after release");
  core_blocked_a: assert property (core_wr_valid && in_prog |=> !nvm_wr_en ##0 wr_refused
    or (nvm_wr_en && wr_refused))
    else $error("core write not refused in program mode");
  serial_gated_a: assert property (ser_wr_valid && !in_prog && !core_wr_valid
    |=> !nvm_wr_en && wr_refused)
    else $error("serial write outside program mode");
  read_req_a: assert property ($rose(req_q) |-> $past(in_prog, 1))
    else $error("readback outside program mode");

  hv_entry_c: cover property ($rose(mode_q == prog_entry_pkg::mode_prog_hv));
  lv_entry_c: cover property ($rose(mode_q == prog_entry_pkg::mode_prog_lv));
  refuse_c: cover property (wr_refused);
endmodule

//--- test/prog_programmer_model.sv
// behavioural programmer on the far side of the serial programming link
// assumes the bench resolves the shared data line from both drivers
module prog_programmer_model (
  // link pins driven by the programmer
  output logic sclk,
  output logic dat,
  output logic master_clear_n_n,
  output logic hv,
  // device side of the data pin
  input wire logic dev_out,
  input wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rd_got = 14'h0;
  int rd_cnt = 0;
  initial begin
    sclk = 1'b0;
    dat = 1'b0;
    master_clear_n_n = 1'b1;
    hv = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock runs only inside these tasks; data moves while the clock is low
  task automatic pulse(input logic b);
    dat = b;
    #80 sclk = 1'b1;
    #40 if (dev_oe === 1'b1) begin
      rd_got = {rd_got[12:0], dev_out};
      rd_cnt++;
    end
    #40 sclk = 1'b0;
  endtask
  // no pull on the line, so a released line keeps changing
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) pulse(~dat);
  endtask
  task automatic hv_entry(input logic dat_lvl);
    sclk = 1'b0;
    dat = dat_lvl;
    #200 hv = 1'b1;
  endtask
  task automatic hv_exit();
    #100 hv = 1'b0;
    dat = ~dat;
  endtask
  // extra leading bits let the arm reach the link side first
  task automatic key_entry(input logic [31:0] key);
    master_clear_n_n = 1'b0;
    #200;
    for (int i = 0; i < 4; i++) pulse(1'b0);
    for (int i = 31; i >= 0; i--) pulse(key[i]);
    dat = ~dat; // master_clear_n stays low until the bench releases it
  endtask
endmodule

//--- test/test_serial_programming_entry.sv
// self-checking bench for the serial programming entry logic
// assumes the programmer model owns the link pins and their clock
`include "prog_entry_defs.svh"
module test_serial_programming_entry;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, prog_serial_clock, model_dat, master_clear_n;
  logic high_prog_voltage_level, low_voltage_prog_enable, master_clear_n_enable_cfg;
  logic ser_wr_valid, core_wr_valid, rd_valid, rd_busy;
  logic [1:0] ser_wr_target, core_wr_target, nvm_wr_target;
  logic [15:0] ser_wr_addr, core_wr_addr, nvm_wr_addr;
  logic [13:0] ser_wr_data, core_wr_data, nvm_wr_data;
  prog_entry_pkg::word_t rd_word;
  logic prog_serial_data_out, prog_serial_data_oe, nvm_wr_en, wr_refused;
  logic prog_mode, prog_mode_hv, master_clear_n_reset_enable, core_reset_n;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  wire data_line = prog_serial_data_oe ? prog_serial_data_out : model_dat;
  serial_programming_entry #(.KEY(`KEY_DEFAULT)) uut (
    .clk_sys, .reset_n, .prog_serial_clock, .prog_serial_data_in(data_line),
    .prog_serial_data_out, .prog_serial_data_oe, .master_clear_n,
    .high_prog_voltage_level, .low_voltage_prog_enable, .master_clear_n_enable_cfg,
    .ser_wr_valid, .ser_wr_target, .ser_wr_addr, .ser_wr_data, .core_wr_valid,
    .core_wr_target, .core_wr_addr, .core_wr_data, .rd_valid, .rd_word, .rd_busy,
    .nvm_wr_en, .nvm_wr_target, .nvm_wr_addr, .nvm_wr_data, .wr_refused,
    .prog_mode, .prog_mode_hv, .master_clear_n_reset_enable, .core_reset_n);
  prog_programmer_model m (.sclk(prog_serial_clock), .dat(model_dat),
    .master_clear_n_n(master_clear_n), .hv(high_prog_voltage_level),
    .dev_out(prog_serial_data_out), .dev_oe(prog_serial_data_oe));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_mode(input logic exp, input string what);
    for (int i = 0; i < 40 && prog_mode !== exp; i++) @(negedge clk_sys);
    check_bit(prog_mode, exp, what);
  endtask
  task automatic wr(input logic ser, input logic [1:0] t, input logic [15:0] a,
    input logic [13:0] d, input logic ok);
    @(negedge clk_sys);
    ser_wr_valid = ser;
    core_wr_valid = ~ser;
    {ser_wr_target, ser_wr_addr, ser_wr_data} = {t, a, d};
    {core_wr_target, core_wr_addr, core_wr_data} = {t, a, d};
    // write and refusal pulses stand for one cycle only: look before the next edge
    @(negedge clk_sys);
    check_bit(nvm_wr_en, ok, "write pulse");
    check_bit(wr_refused, ~ok, "refusal pulse");
    if (ok) check_val({nvm_wr_target, nvm_wr_addr, nvm_wr_data}, {t, a, d}, "word");
    ser_wr_valid = 1'b0;
    core_wr_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_bit(prog_mode | prog_mode_hv, 1'b0, "mode in reset");
    check_bit(core_reset_n, 1'b0, "core held in reset");
    check_bit(master_clear_n_reset_enable, 1'b1, "master_clear_n function in reset");
    check_bit(nvm_wr_en | wr_refused | prog_serial_data_oe, 1'b0, "quiet outputs");
    reset_n = 1'b1;
    settle(4);
    check_bit(core_reset_n, 1'b1, "core released");
    $display("test reset done");
  endtask
  task automatic t_master_clear_n();
    master_clear_n_enable_cfg = 1'b0;
    settle(3);
    check_bit(master_clear_n_reset_enable, 1'b0, "master_clear_n function off");
    low_voltage_prog_enable = 1'b1;
    settle(3);
    check_bit(master_clear_n_reset_enable, 1'b1, "master_clear_n function forced");
    m.master_clear_n_n = 1'b0;
    settle(6);
    check_bit(core_reset_n, 1'b0, "forced master_clear_n resets core");
    m.master_clear_n_n = 1'b1;
    low_voltage_prog_enable = 1'b0;
    master_clear_n_enable_cfg = 1'b1;
    settle(6);
    $display("test master_clear_n done");
  endtask
  task automatic t_hv();
    wr(1'b1, `TGT_PROGRAM, 16'h0010, 14'h2a5c, 1'b0);
    wr(1'b0, `TGT_EEPROM, 16'h0020, 14'h15a3, 1'b1);
    m.hv_entry(1'b1);
    settle(30);
    check_bit(prog_mode, 1'b0, "entry with data high");
    m.hv_exit();
    settle(10);
    m.hv_entry(1'b0);
    wait_mode(1'b1, "high voltage entry");
    check_bit(prog_mode_hv, 1'b1, "entered by voltage");
    check_bit(core_reset_n, 1'b0, "core held in program mode");
    for (int t = 0; t < 4; t++) wr(1'b1, 2'(t), 16'h0100, 14'h3c3c, 1'b1);
    wr(1'b0, `TGT_PROGRAM, 16'h0030, 14'h0fff, 1'b0);
    wr(1'b1, `TGT_CONFIG, `LVP_CFG_ADDR, 14'h1fff, 1'b1);
    m.hv_exit();
    wait_mode(1'b0, "voltage removed");
    $display("test high voltage done");
  endtask
  task automatic t_lv();
    m.key_entry(`KEY_DEFAULT);
    settle(30);
    check_bit(prog_mode, 1'b0, "key while disabled");
    m.master_clear_n_n = 1'b1;
    low_voltage_prog_enable = 1'b1;
    settle(10);
    m.key_entry(`KEY_DEFAULT ^ 32'h0000_0001);
    settle(30);
    check_bit(prog_mode, 1'b0, "wrong key");
    m.master_clear_n_n = 1'b1;
    settle(10);
    m.key_entry(`KEY_DEFAULT);
    wait_mode(1'b1, "key entry");
    check_bit(prog_mode_hv, 1'b0, "entered by key");
    wr(1'b1, `TGT_CONFIG, `LVP_CFG_ADDR, 14'h1fff, 1'b0);
    wr(1'b1, `TGT_CONFIG, `LVP_CFG_ADDR, 14'h3fff, 1'b1);
    t_read(14'h2d96);
    m.master_clear_n_n = 1'b1;
    wait_mode(1'b0, "master clear released");
    $display("test low voltage done");
  endtask
  task automatic t_read(input logic [13:0] w);
    @(negedge clk_sys);
    rd_valid = 1'b1;
    rd_word = w;
    @(negedge clk_sys);
    rd_valid = 1'b0;
    check_bit(rd_busy, 1'b1, "readback busy");
    m.rd_cnt = 0;
    m.idle(30);
    settle(10);
    check_val(32'(m.rd_cnt), 32'd14, "driven bit count");
    check_val({18'h0, m.rd_got}, {18'h0, w}, "readback word");
    check_bit(rd_busy | prog_serial_data_oe, 1'b0, "readback idle");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    low_voltage_prog_enable = 1'b0;
    master_clear_n_enable_cfg = 1'b1;
    {ser_wr_valid, core_wr_valid, rd_valid} = 3'h0;
    {ser_wr_target, ser_wr_addr, ser_wr_data} = 32'h0;
    {core_wr_target, core_wr_addr, core_wr_data} = 32'h0;
    rd_word = 14'h0;
    // link reset goes through a synchroniser, so reset spans link edges too
    #1 m.idle(4);
    settle(8);
    t_reset();
    t_master_clear_n();
    t_hv();
    t_lv();
    complete_run();
  end
endmodule
